// ==== core/sks_params.svh ====
// timing, width and coding constants for the spin knob speed encoder
`ifndef SKS_PARAMS_SVH
`define SKS_PARAMS_SVH
`define SKS_CLK_HZ 40000000
`define SKS_WINDOW_MS 100
`define SKS_STROBE_MS 20
`define SKS_WINDOW_CYC ((`SKS_CLK_HZ / 1000) * `SKS_WINDOW_MS)
`define SKS_STROBE_CYC ((`SKS_CLK_HZ / 1000) * `SKS_STROBE_MS)
`define SKS_TMR_W 23
`define SKS_CNT_W 4
`define SKS_CNT_MAX 4'hF
`define SKS_CNT_ZERO 4'h0
`define SKS_TMR_ZERO 23'h000000
`define SKS_TMR_ONE 23'h000001
`define SKS_RET_W 8
`define SKS_RET_IDLE 8'h00
`define SKS_RET_ONE 8'h01
`define SKS_MSB 3
`endif

// ==== core/sks_pkg.sv ====
// types for the spin knob speed encoder
package sks_pkg;
    typedef enum logic [1:0] {
        SKS_IDLE,
        SKS_WINDOW,
        SKS_STROBE
    } sks_state_t;

    typedef struct packed {
        logic phase_a;
        logic phase_b;
    } sks_quad_t;

    typedef struct packed {
        logic scan_line_zero;
        logic scan_line_one;
        logic scan_line_two;
        logic scan_line_three;
    } sks_scan_t;
endpackage

// ==== core/sks_encoder.sv ====
// spin knob speed and direction encoder toward the keyboard scan controller
`timescale 1ns/10ps
`default_nettype none
`include "sks_params.svh"
module sks_encoder #(
    parameter int unsigned WINDOW_CYCLES = `SKS_WINDOW_CYC,
    parameter int unsigned STROBE_CYCLES = `SKS_STROBE_CYC
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic clk_en_i,
    input wire sks_pkg::sks_quad_t quad_i,
    input wire sks_pkg::sks_scan_t scan_i,
    output logic [`SKS_RET_W-1:0] key_return_lines_o,
    output logic knob_moved_strobe_o,
    output logic turn_direction_flag_o,
    output logic move_pulse_o,
    output logic dir_pulse_o
);
    // durations beyond the timer width would be cut; keep them below 2^23
    localparam logic [`SKS_TMR_W-1:0] WIN_CYC = `SKS_TMR_W'(WINDOW_CYCLES);
    localparam logic [`SKS_TMR_W-1:0] STB_CYC = `SKS_TMR_W'(STROBE_CYCLES);

    sks_pkg::sks_quad_t sync1, sync2, prev;
    sks_pkg::sks_state_t state, next_state;
    logic [`SKS_TMR_W-1:0] timer, next_timer;
    logic [`SKS_CNT_W-1:0] speed_counter, next_speed_counter;
    logic [`SKS_CNT_W-1:0] final_count, next_final_count;
    logic [`SKS_RET_W-1:0] next_ret;
    logic next_strobe, next_dir, next_move, next_dirp;
    logic edge_a, edge_b, move, cw;

    // two-stage synchroniser; sync1 feeds only sync2
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            sync1 <= '0;
            sync2 <= '0;
            prev <= '0;
        end else if (clk_en_i) begin
            sync1 <= quad_i;
            sync2 <= sync1;
            prev <= sync2;
        end
    end

    // edge pulses and quadrature direction
    always_comb begin
        edge_a = sync2.phase_a ^ prev.phase_a;
        edge_b = sync2.phase_b ^ prev.phase_b;
        move = edge_a | edge_b;
        // clockwise when a leads b by a quarter turn
        cw = edge_a ? (sync2.phase_a ^ sync2.phase_b) :
                      ~(sync2.phase_a ^ sync2.phase_b);
    end

    // window, counter and strobe sequencing
    always_comb begin
        next_state = state;
        next_timer = timer;
        next_speed_counter = speed_counter;
        next_final_count = final_count;
        next_strobe = 1'b0;
        next_move = move;
        next_dirp = move & cw;
        next_dir = move ? cw : turn_direction_flag_o;
        case (state)
            sks_pkg::SKS_IDLE: begin
                if (move) begin
                    next_state = sks_pkg::SKS_WINDOW;
                    next_timer = WIN_CYC - `SKS_TMR_ONE;
                    next_speed_counter = `SKS_CNT_ZERO + 4'h1;
                end
            end
            sks_pkg::SKS_WINDOW: begin
                if (move && speed_counter != `SKS_CNT_MAX) begin
                    next_speed_counter = speed_counter + 4'h1;
                end
                if (timer == `SKS_TMR_ZERO) begin
                    next_state = sks_pkg::SKS_STROBE;
                    next_timer = STB_CYC - `SKS_TMR_ONE;
                    next_final_count = next_speed_counter;
                    next_strobe = 1'b1;
                end else begin
                    next_timer = timer - `SKS_TMR_ONE;
                end
            end
            sks_pkg::SKS_STROBE: begin
                // movement during the strobe is not counted or queued
                if (timer == `SKS_TMR_ZERO) begin
                    next_state = sks_pkg::SKS_IDLE;
                    next_speed_counter = `SKS_CNT_ZERO;
                end else begin
                    next_timer = timer - `SKS_TMR_ONE;
                    next_strobe = 1'b1;
                end
            end
            default: begin
                next_state = sks_pkg::SKS_IDLE;
            end
        endcase
    end

    // return line coding, combinational on current scan lines
    always_comb begin
        next_ret = `SKS_RET_IDLE;
        if (state == sks_pkg::SKS_STROBE) begin
            if (!final_count[`SKS_MSB] && scan_i.scan_line_zero) begin
                next_ret = `SKS_RET_ONE << final_count[2:0];
            end
            if (final_count[`SKS_MSB] && scan_i.scan_line_one) begin
                next_ret = `SKS_RET_ONE << final_count[2:0];
            end
        end
    end

    // registers; the return lines lag the scan lines by one clock
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state <= sks_pkg::SKS_IDLE;
            timer <= `SKS_TMR_ZERO;
            speed_counter <= `SKS_CNT_ZERO;
            final_count <= `SKS_CNT_ZERO;
            key_return_lines_o <= `SKS_RET_IDLE;
            knob_moved_strobe_o <= 1'b0;
            turn_direction_flag_o <= 1'b0;
            move_pulse_o <= 1'b0;
            dir_pulse_o <= 1'b0;
        end else if (clk_en_i) begin
            state <= next_state;
            timer <= next_timer;
            speed_counter <= next_speed_counter;
            final_count <= next_final_count;
            key_return_lines_o <= next_ret;
            knob_moved_strobe_o <= next_strobe;
            turn_direction_flag_o <= next_dir;
            move_pulse_o <= next_move;
            dir_pulse_o <= next_dirp;
        end
    end

    sequence s_win_end;
        state == sks_pkg::SKS_WINDOW && timer == `SKS_TMR_ZERO && clk_en_i;
    endsequence

    sequence s_strobe_end;
        state == sks_pkg::SKS_STROBE && timer == `SKS_TMR_ZERO && clk_en_i;
    endsequence

    a_count_saturate: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (speed_counter == `SKS_CNT_MAX && clk_en_i && state != sks_pkg::SKS_STROBE)
        |=> speed_counter == `SKS_CNT_MAX)
        else $error("speed counter left fifteen");
    a_count_step: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (state == sks_pkg::SKS_WINDOW && move && clk_en_i
         && timer != `SKS_TMR_ZERO
         && speed_counter != `SKS_CNT_MAX)
        |=> speed_counter == $past(speed_counter) + 4'h1)
        else $error("speed counter missed a pulse");
    a_window_open: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (state == sks_pkg::SKS_IDLE && move && clk_en_i)
        |=> state == sks_pkg::SKS_WINDOW && timer == WIN_CYC - `SKS_TMR_ONE)
        else $error("window did not open");
    a_strobe_start: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        s_win_end |=> knob_moved_strobe_o && state == sks_pkg::SKS_STROBE)
        else $error("strobe missing after window");
    a_strobe_only: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        knob_moved_strobe_o |-> state == sks_pkg::SKS_STROBE)
        else $error("strobe outside strobe phase");
    a_move_pulse: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (clk_en_i && move) |=> move_pulse_o)
        else $error("edge gave no movement pulse");
    a_dir_subset: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        dir_pulse_o |-> move_pulse_o && turn_direction_flag_o)
        else $error("direction pulse without clockwise movement");
    a_ret_low: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (clk_en_i && state == sks_pkg::SKS_STROBE && !final_count[`SKS_MSB]
         && scan_i.scan_line_zero)
        |=> key_return_lines_o == (`SKS_RET_ONE << $past(final_count[2:0])))
        else $error("low count not on return lines");
    a_ret_high: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (clk_en_i && state == sks_pkg::SKS_STROBE && final_count[`SKS_MSB]
         && scan_i.scan_line_one)
        |=> key_return_lines_o == (`SKS_RET_ONE << $past(final_count[2:0])))
        else $error("high count not on return lines");
    // return lines must stay quiet outside the strobe phase
    a_ret_idle: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (clk_en_i && state != sks_pkg::SKS_STROBE)
        |=> key_return_lines_o == `SKS_RET_IDLE)
        else $error("return lines active outside strobe");
    a_strobe_end: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        s_strobe_end |=> !knob_moved_strobe_o && state == sks_pkg::SKS_IDLE
        && speed_counter == `SKS_CNT_ZERO)
        else $error("strobe did not end cleanly");
    a_window_tick: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (clk_en_i && state == sks_pkg::SKS_WINDOW && timer != `SKS_TMR_ZERO)
        |=> state == sks_pkg::SKS_WINDOW
        && timer == $past(timer) - `SKS_TMR_ONE)
        else $error("window timer did not count down");
    a_dir_flag: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (clk_en_i && move) |=> turn_direction_flag_o == $past(cw))
        else $error("direction flag missed a turn");
    a_dir_pulse: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (clk_en_i && move) |=> dir_pulse_o == $past(cw))
        else $error("direction pulse wrong for turn");
    a_final_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (clk_en_i && state == sks_pkg::SKS_STROBE) |=> $stable(final_count))
        else $error("final count moved during strobe");
    // a low enable must freeze the state, timer, speed counter and return lines
    a_frozen_hold: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        !clk_en_i |=> $stable(state) && $stable(timer)
        && $stable(speed_counter) && $stable(key_return_lines_o))
        else $error("state moved while enable low");
endmodule
`default_nettype wire

// ==== verification/sks_scan_model.sv ====
// scan controller model that walks the scan lines and reads return lines
`timescale 1ns/10ps
`default_nettype none
module sks_scan_model (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic clr_i,
    input wire logic [7:0] key_return_lines_i,
    input wire logic knob_moved_strobe_i,
    output sks_pkg::sks_scan_t scan_o,
    output logic [3:0][7:0] seen_o
);
    logic [1:0] slot;
    logic [1:0] tick;
    // one scan line at a time, four cycles each
    assign scan_o = sks_pkg::sks_scan_t'(4'h8 >> slot);
    // read late in the slot, the encoder answers a cycle behind
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            slot <= 2'h0;
            tick <= 2'h0;
            seen_o <= '0;
        end else begin
            tick <= tick + 2'h1;
            if (tick == 2'h3) begin
                slot <= slot + 2'h1;
            end
            if (clr_i) begin
                seen_o <= '0;
            end else if (tick == 2'h3 && knob_moved_strobe_i) begin
                seen_o[slot] <= seen_o[slot] | key_return_lines_i;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/test_spin_knob_speed_encoder.sv ====
// self-checking bench for the spin knob speed encoder
`timescale 1ns/10ps
`default_nettype none
module test_spin_knob_speed_encoder;
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    // shortened window and strobe so the run stays small
    localparam int WIN = 2000;
    localparam int STB = 400;
    logic clr = 1'b0;
    logic en = 1'b1;
    sks_pkg::sks_quad_t quad = 2'h0;
    sks_pkg::sks_scan_t scan;
    logic [7:0] rl;
    logic strobe, dir_flag, move, dir;
    logic [3:0][7:0] seen;
    int miscompares = 0;
    int num_checks = 0;
    int cycles = 0;
    sks_encoder #(.WINDOW_CYCLES(WIN), .STROBE_CYCLES(STB))
        sks_encoder_inst (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .clk_en_i(en), .quad_i(quad), .scan_i(scan),
        .key_return_lines_o(rl), .knob_moved_strobe_o(strobe),
        .turn_direction_flag_o(dir_flag), .move_pulse_o(move),
        .dir_pulse_o(dir));
    sks_scan_model sks_scan_model_inst (.sys_clk_i(sys_clk_i),
        .srst_i(srst_i), .clr_i(clr), .key_return_lines_i(rl),
        .knob_moved_strobe_i(strobe), .scan_o(scan), .seen_o(seen));
    initial begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    // two shortened windows and strobes need about 4,900 cycles
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        num_checks++;
        if (got !== want) begin
            miscompares++;
            $display("[FAIL] %0t got %h want %h", $time, got, want);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #2;
    endtask
    // one gray step; clockwise lets phase a lead phase b
    task automatic step(input logic cw);
        int i;
        if ((quad.phase_a == quad.phase_b) == cw) begin
            quad.phase_a = ~quad.phase_a;
        end else begin
            quad.phase_b = ~quad.phase_b;
        end
        for (i = 0; i < 6 && move !== 1'b1; i++) tick(1);
        check({7'h00, move}, 8'h01);
        check({7'h00, dir}, {7'h00, cw});
        tick(1);
        check({7'h00, move}, 8'h00);
        tick(6);
    endtask
    // turn, time window and strobe, then read the coded count
    task automatic t_window(input logic cw, input int n, input logic [3:0] c,
        input int f);
        int t0;
        logic [7:0] e;
        e = 8'h01 << c[2:0];
        clr = 1'b1;
        tick(1);
        clr = 1'b0;
        t0 = cycles + 3;
        repeat (n) step(cw);
        check({7'h00, dir_flag}, {7'h00, cw});
        // a low enable must stretch the window by exactly its length
        if (f > 0) begin
            en = 1'b0;
            tick(f);
            check({7'h00, strobe | move}, 8'h00);
            en = 1'b1;
        end
        while (strobe !== 1'b1 && cycles - t0 < WIN + f + 100) tick(1);
        check(cycles - t0, WIN + f);
        t0 = cycles;
        while (strobe === 1'b1 && cycles - t0 < STB + 100) tick(1);
        check(cycles - t0, STB);
        check(seen[0], c[3] ? 8'h00 : e);
        check(seen[1], c[3] ? e : 8'h00);
        check(seen[2] | seen[3], 8'h00);
    endtask
    task automatic complete_run();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        tick(4);
        srst_i = 1'b0;
        tick(1);
        check(rl, 8'h00);
        check({7'h00, strobe}, 8'h00);
        t_window(1'b1, 3, 4'h3, 0);
        t_window(1'b0, 20, 4'hF, 50);
        complete_run();
    end
endmodule
`default_nettype wire
